// ---- verilog/pcir_config_bank.sv ----
// indexed configuration bank with wait-state, dma clock and strobe control
//
// Notes on behaviour
// RULE1: registers reached through an index port and a data port by I/O cycles.
// RULE2: software writes the index first, then accesses the data port.
// RULE3: index write is latched and steers later data-port accesses.
// RULE4: register 1 bits 7:6 give 1..4 I/O wait states, reset 11.
// RULE5: ready held low exactly the programmed number of AT clocks.
// RULE6: bits 5:4 give 1..4 wait states for 16-bit DMA, reset 00.
// RULE7: bits 3:2 give 1..4 wait states for 8-bit DMA, reset 00.
// RULE8: bit 1 clear delays memory read one DMA clock after I/O read.
// RULE9: bit 0 selects DMA clock as AT clock halved or undivided.
// RULE10: DMA clock switch is synchronised so no short pulse appears.
// RULE11: register 2 bit 2 selects test mode, reset normal.
// RULE12: register 2 bit 1 enables the per-IRQ trigger selections.
// RULE13: register 2 bit 0 low enables DMA extended mode.
// RULE14: register 3 bits 7:3 select IRQ7..3 trigger type; 2:0 reserved.
// RULE15: register 4 selects IRQ15,14,12,11,10,9; bits 5 and 0 reserved zero.
// RULE16: edge-triggered inputs are non-sharable, level ones sharable.
// RULE17: three-bit trim tunes the 32 kHz oscillator, non-linearly.
// RULE18: each set trim bit adds one load capacitor step.
// RULE19: all registers reset to defaults; reserved bits read zero.
`timescale 1ns/1ps
`include "pcir_consts.svh"
module pcir_config_bank
    import pcir_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    input  wire logic              clock,
    input  wire logic              rst,
    input  wire logic              io_wr,
    input  wire logic              io_rd,
    input  wire logic [ADDR_W-1:0] io_addr,
    input  wire logic [7:0]        io_wdata,
    output logic      [7:0]        io_rdata,
    output logic                   io_rvalid,
    input  wire logic              at_bus_clock,
    input  wire logic              isa_cycle_start,
    input  wire pcir_pkg::pcir_cyc_t isa_cycle_kind,
    output logic                   iochrdy,
    input  wire logic              dma_ior_req,
    output logic                   dma_ior,
    output logic                   dma_memr,
    output logic                   dma_clock,
    output logic                   test_mode,
    output logic                   dma_ext_enable,
    output logic [15:0]            irq_level_mode,
    output logic [15:0]            irq_sharable,
    output logic [2:0]             osc_trim_caps
);
    ////////////////////////////////////////////////////////////////////////
    logic [7:0] index_r;
    logic [7:0] cfg_one_r;
    logic [7:0] cfg_two_r;
    logic [7:0] trig_low_r;
    logic [7:0] trig_high_r;
    logic [7:0] osc_trim_r;
    logic       index_hit;
    logic       data_hit;

    assign index_hit = (io_addr[7:0] == `PCIR_PORT_INDEX);  // RULE1
    assign data_hit  = (io_addr[7:0] == `PCIR_PORT_DATA);   // RULE1

    function automatic logic [7:0] pcir_read_sel(input logic [7:0] idx,
            input logic [7:0] r1, input logic [7:0] r2, input logic [7:0] r3,
            input logic [7:0] r4, input logic [7:0] r5);
        logic [7:0] v;
        v = 8'h00;
        unique case (idx)
            `PCIR_IDX_CFG_ONE:   v = r1 & `PCIR_MASK_CFG_ONE;
            `PCIR_IDX_CFG_TWO:   v = r2 & `PCIR_MASK_CFG_TWO;
            `PCIR_IDX_TRIG_LOW:  v = r3 & `PCIR_MASK_TRIG_LOW;
            `PCIR_IDX_TRIG_HIGH: v = r4 & `PCIR_MASK_TRIG_HIGH;
            `PCIR_IDX_OSC_TRIM:  v = r5 & `PCIR_MASK_OSC_TRIM;
            default:             v = 8'h00;
        endcase
        return v;
    endfunction : pcir_read_sel

    // index latch; data port follows whatever was last written here
    always_ff @(posedge clock) begin
        if (rst) begin
            index_r <= 8'h00;
        end else if (io_wr && index_hit) begin
            index_r <= io_wdata;  // RULE3
        end
    end

    // reserved bits are masked on write so they can never read back set
    always_ff @(posedge clock) begin
        if (rst) begin
            cfg_one_r   <= `PCIR_RST_CFG_ONE;  // RULE19
            cfg_two_r   <= `PCIR_RST_CFG_TWO;
            trig_low_r  <= `PCIR_RST_TRIG_LOW;
            trig_high_r <= `PCIR_RST_TRIG_HIGH;
            osc_trim_r  <= `PCIR_RST_OSC_TRIM;
        end else if (io_wr && data_hit) begin
            unique case (index_r)  // RULE3
                `PCIR_IDX_CFG_ONE:   cfg_one_r   <= io_wdata & `PCIR_MASK_CFG_ONE;
                `PCIR_IDX_CFG_TWO:   cfg_two_r   <= io_wdata & `PCIR_MASK_CFG_TWO;
                `PCIR_IDX_TRIG_LOW:  trig_low_r  <= io_wdata & `PCIR_MASK_TRIG_LOW;  // RULE14
                `PCIR_IDX_TRIG_HIGH: trig_high_r <= io_wdata & `PCIR_MASK_TRIG_HIGH; // RULE15
                `PCIR_IDX_OSC_TRIM:  osc_trim_r  <= io_wdata & `PCIR_MASK_OSC_TRIM;
                default: ;
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            io_rdata  <= 8'h00;
            io_rvalid <= 1'b0;
        end else begin
            io_rvalid <= io_rd && (index_hit || data_hit);
            if (io_rd && index_hit) begin
                io_rdata <= index_r;
            end else if (io_rd && data_hit) begin
                io_rdata <= pcir_read_sel(index_r, cfg_one_r, cfg_two_r,
                                          trig_low_r, trig_high_r, osc_trim_r); // RULE19
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // at clock is sampled synchronously; edge from two history stages
    logic at_q1_r;
    logic at_q2_r;
    logic at_rise;
    always_ff @(posedge clock) begin
        if (rst) begin
            at_q1_r <= 1'b0;
            at_q2_r <= 1'b0;
        end else begin
            at_q1_r <= at_bus_clock;
            at_q2_r <= at_q1_r;
        end
    end
    assign at_rise = at_q1_r && !at_q2_r;

    ////////////////////////////////////////////////////////////////////////
    pcir_ws_state_t ws_state_r;
    logic [2:0]     ws_left_r;
    logic [1:0]     ws_code;
    always_comb begin
        unique case (isa_cycle_kind)
            PCIR_CYC_DMA16: ws_code = cfg_one_r[`PCIR_DMA16_HI:`PCIR_DMA16_LO];  // RULE6
            PCIR_CYC_DMA8:  ws_code = cfg_one_r[`PCIR_DMA8_HI:`PCIR_DMA8_LO];    // RULE7
            default:        ws_code = cfg_one_r[`PCIR_IOWAIT_HI:`PCIR_IOWAIT_LO]; // RULE4
        endcase
    end

    // code n gives n+1 AT clocks of ready deasserted
    always_ff @(posedge clock) begin
        if (rst) begin
            ws_state_r <= PCIR_IDLE;
            ws_left_r  <= 3'h0;
            iochrdy    <= 1'b1;
        end else begin
            unique case (ws_state_r)
                PCIR_IDLE: begin
                    if (isa_cycle_start) begin
                        ws_state_r <= PCIR_WAIT;
                        ws_left_r  <= {1'b0, ws_code} + 3'h1;  // RULE5
                        iochrdy    <= 1'b0;
                    end
                end
                PCIR_WAIT: begin
                    if (at_rise) begin
                        if (ws_left_r == 3'h1) begin
                            ws_state_r <= PCIR_READY;
                            iochrdy    <= 1'b1;  // RULE5
                        end
                        ws_left_r <= ws_left_r - 3'h1;
                    end
                end
                PCIR_READY: ws_state_r <= PCIR_IDLE;
                default:    ws_state_r <= PCIR_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // divider changes source only at a point where both candidates are low,
    // so the switch never emits a shortened pulse
    logic div_r;
    logic full_sel_r;
    logic dma_clk_nxt;
    always_ff @(posedge clock) begin
        if (rst) begin
            div_r <= 1'b0;
        end else if (at_rise) begin
            div_r <= !div_r;  // RULE9
        end
    end
    always_ff @(posedge clock) begin
        if (rst) begin
            full_sel_r <= 1'b0;
        end else if (!at_q1_r && !div_r) begin
            full_sel_r <= cfg_one_r[`PCIR_DMACLK_FULL];  // RULE10
        end
    end
    assign dma_clk_nxt = full_sel_r ? at_q1_r : div_r;  // RULE9
    always_ff @(posedge clock) begin
        if (rst) begin
            dma_clock <= 1'b0;
        end else begin
            dma_clock <= dma_clk_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    logic dma_clk_rise;
    assign dma_clk_rise = dma_clk_nxt && !dma_clock;
    always_ff @(posedge clock) begin
        if (rst) begin
            dma_ior  <= 1'b0;
            dma_memr <= 1'b0;
        end else begin
            dma_ior <= dma_ior_req;
            if (!dma_ior_req) begin
                dma_memr <= 1'b0;
            end else if (cfg_one_r[`PCIR_MEMR_NODLY]) begin
                dma_memr <= 1'b1;  // RULE8
            end else if (dma_ior && dma_clk_rise) begin
                dma_memr <= 1'b1;  // RULE8
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    logic [15:0] level_sel;
    assign level_sel = {trig_high_r[7:6], 1'b0, trig_high_r[4:1], 1'b0,
                        trig_low_r[7:3], 3'b000};
    always_ff @(posedge clock) begin
        if (rst) begin
            test_mode      <= 1'b0;
            dma_ext_enable <= 1'b1;
            irq_level_mode <= 16'h0000;
            irq_sharable   <= 16'h0000;
            osc_trim_caps  <= 3'h0;
        end else begin
            test_mode      <= cfg_two_r[`PCIR_TEST_MODE];    // RULE11
            dma_ext_enable <= !cfg_two_r[`PCIR_DMAEXT_OFF];  // RULE13
            irq_level_mode <= cfg_two_r[`PCIR_IRQCFG_EN] ? level_sel : 16'h0000; // RULE12
            irq_sharable   <= cfg_two_r[`PCIR_IRQCFG_EN] ? level_sel : 16'h0000; // RULE16
            osc_trim_caps  <= osc_trim_r[2:0];  // RULE17 RULE18
        end
    end

    ////////////////////////////////////////////////////////////////////////
    a_index_latch: assert property (@(posedge clock) disable iff (rst) // RULE3
        io_wr && index_hit |=> index_r == $past(io_wdata))
        else $error("index not latched");
    a_reset_iowait: assert property (@(posedge clock) // RULE4
        rst |=> cfg_one_r[7:6] == 2'b11)
        else $error("io wait reset wrong");
    a_ready_low: assert property (@(posedge clock) disable iff (rst) // RULE5
        $fell(iochrdy) |=> !iochrdy until (ws_left_r == 3'h0))
        else $error("ready released early");
    a_memr_nodly: assert property (@(posedge clock) disable iff (rst) // RULE8
        dma_ior_req && cfg_one_r[1] |=> dma_memr)
        else $error("memr not immediate");
    a_memr_order: assert property (@(posedge clock) disable iff (rst) // RULE8
        $rose(dma_memr) && !$past(cfg_one_r[1]) |-> $past(dma_ior))
        else $error("memr before ior");
    a_test_mode: assert property (@(posedge clock) disable iff (rst) // RULE11
        ##1 test_mode == $past(cfg_two_r[2]))
        else $error("test mode mismatch");
    a_irq_gate: assert property (@(posedge clock) disable iff (rst) // RULE12
        !$past(cfg_two_r[1]) |-> irq_level_mode == 16'h0000)
        else $error("irq selection not gated");
    a_dmaext_pol: assert property (@(posedge clock) disable iff (rst) // RULE13
        ##1 dma_ext_enable != $past(cfg_two_r[0]))
        else $error("extended mode polarity");
    a_reserved_zero: assert property (@(posedge clock) disable iff (rst) // RULE15
        trig_high_r[5] == 1'b0 && trig_high_r[0] == 1'b0 && trig_low_r[2:0] == 3'h0)
        else $error("reserved bit set");
    a_rvalid_pulse: assert property (@(posedge clock) disable iff (rst) // RULE1
        ##1 io_rvalid == $past(io_rd && (index_hit || data_hit)))
        else $error("read valid wrong");
    a_index_read: assert property (@(posedge clock) disable iff (rst) // RULE3
        io_rd && index_hit |=> io_rdata == $past(index_r))
        else $error("index readback wrong");
    a_ws_start: assert property (@(posedge clock) disable iff (rst) // RULE5
        ws_state_r == PCIR_IDLE && isa_cycle_start |=> !iochrdy)
        else $error("ready not dropped");
    a_ready_rise: assert property (@(posedge clock) disable iff (rst) // RULE5
        $rose(iochrdy) |-> $past(at_rise))
        else $error("ready rose off an at clock edge");
    a_memr_drop: assert property (@(posedge clock) disable iff (rst) // RULE8
        !dma_ior_req |=> !dma_ior && !dma_memr)
        else $error("dma strobes not dropped");
    a_dmaclk_full: assert property (@(posedge clock) disable iff (rst) // RULE9
        $past(full_sel_r) |-> dma_clock == $past(at_q1_r))
        else $error("undivided dma clock wrong");
    a_sharable_eq: assert property (@(posedge clock) disable iff (rst) // RULE16
        irq_sharable == irq_level_mode)
        else $error("sharable and level differ");
    a_trim_follow: assert property (@(posedge clock) disable iff (rst) // RULE17 RULE18
        ##1 osc_trim_caps == $past(osc_trim_r[2:0]))
        else $error("trim caps mismatch");
    a_reset_others: assert property (@(posedge clock) // RULE19
        rst |=> index_r == 8'h00 && cfg_two_r == `PCIR_RST_CFG_TWO
            && trig_low_r == `PCIR_RST_TRIG_LOW && trig_high_r == `PCIR_RST_TRIG_HIGH
            && osc_trim_r == `PCIR_RST_OSC_TRIM)
        else $error("config reset wrong");
endmodule : pcir_config_bank

// ---- inc/pcir_consts.svh ----
// offsets, field positions, reset values and masks of the indexed config bank
`ifndef PCIR_CONSTS_SVH
`define PCIR_CONSTS_SVH
`define PCIR_PORT_INDEX      8'h22
`define PCIR_PORT_DATA       8'h23
`define PCIR_IDX_CFG_ONE     8'h01
`define PCIR_IDX_CFG_TWO     8'h02
`define PCIR_IDX_TRIG_LOW    8'h03
`define PCIR_IDX_TRIG_HIGH   8'h04
`define PCIR_IDX_OSC_TRIM    8'h05
`define PCIR_RST_CFG_ONE     8'hc0
`define PCIR_RST_CFG_TWO     8'h00
`define PCIR_RST_TRIG_LOW    8'h00
`define PCIR_RST_TRIG_HIGH   8'h00
`define PCIR_RST_OSC_TRIM    8'h00
`define PCIR_MASK_CFG_ONE    8'hff
`define PCIR_MASK_CFG_TWO    8'h07
`define PCIR_MASK_TRIG_LOW   8'hf8
`define PCIR_MASK_TRIG_HIGH  8'hde
`define PCIR_MASK_OSC_TRIM   8'h07
`define PCIR_IOWAIT_HI       7
`define PCIR_IOWAIT_LO       6
`define PCIR_DMA16_HI        5
`define PCIR_DMA16_LO        4
`define PCIR_DMA8_HI         3
`define PCIR_DMA8_LO         2
`define PCIR_MEMR_NODLY      1
`define PCIR_DMACLK_FULL     0
`define PCIR_TEST_MODE       2
`define PCIR_IRQCFG_EN       1
`define PCIR_DMAEXT_OFF      0
`endif

// ---- inc/pcir_pkg.sv ----
// types of the indexed config bank
package pcir_pkg;
    typedef enum logic [1:0] {
        PCIR_IDLE  = 2'b00,
        PCIR_WAIT  = 2'b01,
        PCIR_READY = 2'b11
    } pcir_ws_state_t;
    typedef enum logic [1:0] {
        PCIR_CYC_IO    = 2'b00,
        PCIR_CYC_DMA16 = 2'b01,
        PCIR_CYC_DMA8  = 2'b10
    } pcir_cyc_t;
endpackage : pcir_pkg

// ---- testbench/pcir_host_model.sv ----
// host model issuing single-byte i/o cycles to the config bank
`timescale 1ns/1ps
module pcir_host_model (
    input  wire logic       clock,
    output logic            io_wr,
    output logic            io_rd,
    output logic [7:0]      io_addr,
    output logic [7:0]      io_wdata,
    input  wire logic [7:0] io_rdata,
    input  wire logic       io_rvalid
);
    initial begin
        io_wr = 1'b0;
        io_rd = 1'b0;
        io_addr = 8'h00;
        io_wdata = 8'h00;
    end
    ////////////////////////////////////////////////////////////////////////////
    // released lines show the inverse so stale values never pass for a match
    task automatic put(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        io_wr <= 1'b1;
        io_addr <= a;
        io_wdata <= d;
        @(posedge clock);
        io_wr <= 1'b0;
        io_addr <= ~a;
        io_wdata <= ~d;
    endtask : put
    task automatic get(input logic [7:0] a, output logic [7:0] d, output logic v);
        @(posedge clock);
        io_rd <= 1'b1;
        io_addr <= a;
        @(posedge clock);
        io_rd <= 1'b0;
        io_addr <= ~a;
        @(posedge clock);
        d = io_rdata;
        v = io_rvalid;
    endtask : get
endmodule : pcir_host_model

// ---- testbench/pcir_config_bank_tb.sv ----
// self-checking bench of the indexed config bank
`timescale 1ns/1ps
`include "pcir_consts.svh"
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin error_cnt++; \
    $display("ERROR t=%0t got=%0h exp=%0h", $time, (g), (e)); end end
module pcir_config_bank_tb;
    import pcir_pkg::*;
    logic            clock = 1'b0;
    logic            rst = 1'b1;
    logic            at_bus_clock = 1'b0;
    logic            isa_cycle_start = 1'b0;
    pcir_cyc_t       isa_cycle_kind = PCIR_CYC_IO;
    logic            dma_ior_req = 1'b0;
    logic            io_wr, io_rd, io_rvalid, iochrdy, dma_ior, dma_memr, dma_clock;
    logic            test_mode, dma_ext_enable;
    logic [7:0]      io_addr, io_wdata, io_rdata;
    logic [15:0]     irq_level_mode, irq_sharable;
    logic [2:0]      osc_trim_caps;
    logic [7:0]      sh [1:5];
    logic [7:0]      mk [1:5] = '{`PCIR_MASK_CFG_ONE, `PCIR_MASK_CFG_TWO,
        `PCIR_MASK_TRIG_LOW, `PCIR_MASK_TRIG_HIGH, `PCIR_MASK_OSC_TRIM};
    logic [7:0]      rv [1:5] = '{`PCIR_RST_CFG_ONE, `PCIR_RST_CFG_TWO,
        `PCIR_RST_TRIG_LOW, `PCIR_RST_TRIG_HIGH, `PCIR_RST_OSC_TRIM};
    int              seed = 32'ha293;
    int              error_cnt = 0;
    int              n_checks = 0;
    int              cyc = 0;
    int              run = 0;
    logic            dma_prev = 1'b0;
    always #25 clock = ~clock;
    pcir_config_bank dut (.clock(clock), .rst(rst), .io_wr(io_wr), .io_rd(io_rd),
        .io_addr(io_addr), .io_wdata(io_wdata), .io_rdata(io_rdata), .io_rvalid(io_rvalid),
        .at_bus_clock(at_bus_clock), .isa_cycle_start(isa_cycle_start),
        .isa_cycle_kind(isa_cycle_kind), .iochrdy(iochrdy), .dma_ior_req(dma_ior_req),
        .dma_ior(dma_ior), .dma_memr(dma_memr), .dma_clock(dma_clock),
        .test_mode(test_mode), .dma_ext_enable(dma_ext_enable),
        .irq_level_mode(irq_level_mode), .irq_sharable(irq_sharable),
        .osc_trim_caps(osc_trim_caps));
    pcir_host_model host (.clock(clock), .io_wr(io_wr), .io_rd(io_rd), .io_addr(io_addr),
        .io_wdata(io_wdata), .io_rdata(io_rdata), .io_rvalid(io_rvalid));
    ////////////////////////////////////////////////////////////////////////////
    // at clock runs at one eighth of clock, slow enough for the sampler
    always @(posedge clock) begin
        cyc <= cyc + 1;
        at_bus_clock <= cyc[2];
        run <= (dma_clock !== dma_prev) ? 1 : run + 1;
        dma_prev <= dma_clock;
        if (!rst && dma_clock !== dma_prev && cyc > 40)
            `CHK(run >= 4, 1'b1)
        if (cyc == 20000) begin
            error_cnt++;
            wrap_up();
        end
    end
    function automatic logic [15:0] xirq(input logic [7:0] r2, r3, r4);
        xirq = {r4[7:6], 1'b0, r4[4:1], 1'b0, r3[7:3], 3'b000};
        if (!r2[1])
            xirq = 16'h0000;
    endfunction : xirq
    task automatic wreg(input int i, input logic [7:0] w);
        w = w & ((i == 4) ? 8'hde : 8'hff);
        host.put(8'h22, 8'(i));
        host.put(8'h23, w);
        sh[i] = w & mk[i];
    endtask : wreg
    task automatic chk_regs();
        logic [7:0] d;
        logic       v;
        for (int i = 1; i <= 5; i++) begin
            host.put(8'h22, 8'(i));
            host.get(8'h23, d, v);
            `CHK(v, 1'b1)
            `CHK(d, sh[i])
        end
        `CHK(test_mode, sh[2][2])
        `CHK(dma_ext_enable, ~sh[2][0])
        `CHK(irq_level_mode, xirq(sh[2], sh[3], sh[4]))
        `CHK(irq_sharable, xirq(sh[2], sh[3], sh[4]))
        `CHK(osc_trim_caps, sh[5][2:0])
    endtask : chk_regs
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : wrap_up
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        logic [7:0] d;
        logic [7:0] w;
        logic       v;
        logic       p;
        int         n;
        int         t;
        repeat (16) @(posedge clock);
        rst <= 1'b0;
        sh = rv;
        chk_regs();
        $display("test reset values done");
        repeat (6) begin
            for (int i = 1; i <= 5; i++)
                wreg(i, 8'($random(seed)));
            chk_regs();
        end
        $display("test random access done");
        rst <= 1'b1;
        repeat (4) @(posedge clock);
        rst <= 1'b0;
        sh = rv;
        chk_regs();
        $display("test mid-run reset done");
        host.put(8'h22, 8'h06);
        host.put(8'h23, 8'hff);
        host.get(8'h23, d, v);
        `CHK(d, 8'h00)
        host.get(8'h22, d, v);
        `CHK(d, 8'h06)
        `CHK(v, 1'b1)
        host.get(8'h24, d, v);
        `CHK(v, 1'b0)
        host.put(8'h24, 8'h5a);
        wreg(2, 8'hff);
        wreg(3, 8'hff);
        wreg(5, 8'hff);
        chk_regs();
        $display("test unmapped and reserved done");
        for (int k = 0; k < 4; k++) begin
            for (int c = 0; c < 4; c++) begin
                w = 8'($random(seed));
                w[((k == 1) ? 4 : (k == 2) ? 2 : 6) +: 2] = c[1:0];
                wreg(1, w);
                do @(posedge clock); while (cyc[2:0] != 3'd0);
                isa_cycle_start <= 1'b1;
                isa_cycle_kind <= pcir_cyc_t'(k[1:0]);
                @(posedge clock);
                isa_cycle_start <= 1'b0;
                n = 0;
                p = 1'b0;
                t = 0;
                do begin
                    @(posedge clock);
                    n += (at_bus_clock && !p) ? 1 : 0;
                    p = at_bus_clock;
                    t++;
                end while (iochrdy !== 1'b1 && t < 200);
                `CHK(n, c + 1)
            end
        end
        $display("test wait states done");
        for (int m = 0; m < 2; m++) begin
            wreg(1, {6'h30, m[0], m[0]});
            dma_ior_req <= 1'b1;
            repeat (2) @(posedge clock);
            `CHK(dma_ior, 1'b1)
            `CHK(dma_memr, m[0])
            for (t = 0; t < 40 && dma_memr !== 1'b1; t++)
                @(posedge clock);
            `CHK(dma_memr, 1'b1)
            dma_ior_req <= 1'b0;
            repeat (2) @(posedge clock);
            `CHK({dma_ior, dma_memr}, 2'b00)
            repeat (40) @(posedge clock);
            n = 0;
            t = 0;
            p = dma_clock;
            for (int g = 0; g < 100 && n < 2; g++) begin
                @(posedge clock);
                n += (dma_clock && !p) ? 1 : 0;
                t += (n == 1) ? 1 : 0;
                p = dma_clock;
            end
            `CHK(t, 16 - 8 * m)
        end
        $display("test dma strobes and clock done");
        wrap_up();
    end
endmodule : pcir_config_bank_tb
